// ==== src/epm_map.vh ====
// Address map and endpoint layout constants for the endpoint memory map block
`ifndef EPM_MAP_VH
`define EPM_MAP_VH

`define EPM_PRG_BASE     16'h0000
`define EPM_PRG_LAST     16'h3FFF
`define EPM_SCR_BASE     16'hE000
`define EPM_SCR_LAST     16'hE1FF
`define EPM_WAV_BASE     16'hE400
`define EPM_WAV_LAST     16'hE47F
`define EPM_CSR_BASE     16'hE500
`define EPM_CSR_LAST     16'hE6FF
`define EPM_SETUP_BASE   16'hE6B8
`define EPM_SETUP_LAST   16'hE6BF
`define EPM_EP0_BASE     16'hE740
`define EPM_EP1O_BASE    16'hE780
`define EPM_EP1I_BASE    16'hE7C0
`define EPM_SMALL_LAST   16'hE7FF
`define EPM_BIG_BASE     16'hF000
`define EPM_BIG_LAST     16'hFFFF

// Region codes
`define EPM_RG_NONE      4'h0
`define EPM_RG_PRG       4'h1
`define EPM_RG_SCR       4'h2
`define EPM_RG_WAV       4'h3
`define EPM_RG_CSR       4'h4
`define EPM_RG_SETUP     4'h5
`define EPM_RG_EP0       4'h6
`define EPM_RG_EP1O      4'h7
`define EPM_RG_EP1I      4'h8
`define EPM_RG_BIG       4'h9

// Transfer types
`define EPM_TT_NONE      2'h0
`define EPM_TT_BULK      2'h1
`define EPM_TT_INT       2'h2
`define EPM_TT_ISO       2'h3

`define EPM_NUM_CFG      4'hC
`define EPM_FS_PKT       11'h040
`define EPM_HS_PKT       11'h200
`define EPM_SMALL_PKT    11'h040
`define EPM_BUF_BYTES    10'h200
`define EPM_NUM_ALT      2'h3

`endif

// ==== src/epm_region_dec.v ====
// Address-to-region decoder for the processor data space
`include "epm_map.vh"

module epm_region_dec (
	input  wire [15:0] addr,
	input  wire        dl_path,
	output reg  [3:0]  region,
	output reg  [15:0] offset
);

	always @* begin
		region = `EPM_RG_NONE;
		offset = 16'h0000;
		if (addr <= `EPM_PRG_LAST) begin
			region = `EPM_RG_PRG;
			offset = addr;
		end else if (addr >= `EPM_SCR_BASE && addr <= `EPM_SCR_LAST) begin
			region = `EPM_RG_SCR;
			offset = addr - `EPM_SCR_BASE;
		end else if (dl_path) begin
			region = `EPM_RG_NONE;
		end else if (addr >= `EPM_WAV_BASE && addr <= `EPM_WAV_LAST) begin
			region = `EPM_RG_WAV;
			offset = addr - `EPM_WAV_BASE;
		end else if (addr >= `EPM_SETUP_BASE && addr <= `EPM_SETUP_LAST) begin
			region = `EPM_RG_SETUP;
			offset = addr - `EPM_SETUP_BASE;
		end else if (addr >= `EPM_CSR_BASE && addr <= `EPM_CSR_LAST) begin
			region = `EPM_RG_CSR;
			offset = addr - `EPM_CSR_BASE;
		end else if (addr >= `EPM_EP0_BASE && addr < `EPM_EP1O_BASE) begin
			region = `EPM_RG_EP0;
			offset = addr - `EPM_EP0_BASE;
		end else if (addr >= `EPM_EP1O_BASE && addr < `EPM_EP1I_BASE) begin
			region = `EPM_RG_EP1O;
			offset = addr - `EPM_EP1O_BASE;
		end else if (addr >= `EPM_EP1I_BASE && addr <= `EPM_SMALL_LAST) begin
			region = `EPM_RG_EP1I;
			offset = addr - `EPM_EP1I_BASE;
		end else if (addr >= `EPM_BIG_BASE) begin
			region = `EPM_RG_BIG;
			offset = addr - `EPM_BIG_BASE;
		end
	end

endmodule

// ==== src/epm_endpoint_memory_map.v ====
// Memory map and endpoint buffer layout of the USB peripheral controller
`include "epm_map.vh"

module epm_endpoint_memory_map (
	input  wire        ref_clk,
	input  wire        sys_rst,
	// Processor or download data access
	input  wire        mem_req,
	input  wire        mem_we,
	input  wire        mem_dl_path,
	input  wire [15:0] mem_addr,
	input  wire [7:0]  mem_wdata,
	output reg  [7:0]  mem_rdata,
	output reg         mem_ack,
	output reg         mem_hit,
	// Control register window handed to the register file outside
	output wire        csr_sel,
	input  wire [7:0]  csr_rdata,
	// Endpoint layout selection
	input  wire [3:0]  cfg_sel,
	input  wire [1:0]  alt_sel,
	input  wire        high_speed,
	output reg  [3:0]  cfg_active,
	output reg         cfg_bad,
	output reg  [2:0]  depth_ep2,
	output reg  [2:0]  depth_ep4,
	output reg  [2:0]  depth_ep6,
	output reg  [2:0]  depth_ep8,
	output reg  [10:0] pkt_ep2,
	output reg  [10:0] pkt_ep6,
	output reg  [1:0]  type_ep1,
	output reg  [1:0]  type_ep2,
	output reg  [1:0]  type_ep4,
	output reg  [1:0]  type_ep6,
	output reg  [1:0]  type_ep8,
	output reg  [10:0] ep1_report_pkt,
	output reg  [10:0] ep1_hold_pkt,
	output reg  [10:0] ep0_pkt
);

	wire [3:0]  region;
	wire [15:0] offset;

	reg [7:0] prg_mem   [0:16383];
	reg [7:0] scr_mem   [0:511];
	reg [7:0] wav_mem   [0:127];
	reg [7:0] setup_mem [0:7];
	reg [7:0] small_mem [0:191];
	reg [7:0] big_mem   [0:4095];

	reg [3:0]  cfg_reg;
	reg [1:0]  alt_reg;
	reg        hs_reg;
	reg [2:0]  d2_next;
	reg [2:0]  d6_next;
	reg [10:0] p2_next;
	reg [10:0] p6_next;
	reg [7:0]  rd_next;

	////////////////////////////////////////////////////////////////////////////////
	// Address decode

	epm_region_dec i_epm_region_dec (
		.addr    (mem_addr),
		.dl_path (mem_dl_path),
		.region  (region),
		.offset  (offset)
	);

	assign csr_sel = mem_req && (region == `EPM_RG_CSR);

	// Full speed keeps accesses in the first 64 bytes of each 512-byte block
	wire        big_ok = hs_reg || (offset[8:6] == 3'h0);
	wire [7:0]  small_idx = (region == `EPM_RG_EP0)  ? {2'h0, offset[5:0]} :
				(region == `EPM_RG_EP1O) ? {2'h1, offset[5:0]} :
				{2'h2, offset[5:0]};

	////////////////////////////////////////////////////////////////////////////////
	// Memory access

	always @(posedge ref_clk) begin
		if (mem_req && mem_we) begin
			if (region == `EPM_RG_PRG)
				prg_mem[offset[13:0]] <= mem_wdata;
			else if (region == `EPM_RG_SCR)
				scr_mem[offset[8:0]] <= mem_wdata;
			else if (region == `EPM_RG_WAV)
				wav_mem[offset[6:0]] <= mem_wdata;
			else if (region == `EPM_RG_SETUP)
				setup_mem[offset[2:0]] <= mem_wdata;
			else if (region == `EPM_RG_EP0 || region == `EPM_RG_EP1O ||
				region == `EPM_RG_EP1I)
				small_mem[small_idx] <= mem_wdata;
			else if (region == `EPM_RG_BIG && big_ok)
				big_mem[offset[11:0]] <= mem_wdata;
		end
	end

	always @* begin
		rd_next = 8'h00;
		if (region == `EPM_RG_PRG)
			rd_next = prg_mem[offset[13:0]];
		else if (region == `EPM_RG_SCR)
			rd_next = scr_mem[offset[8:0]];
		else if (region == `EPM_RG_WAV)
			rd_next = wav_mem[offset[6:0]];
		else if (region == `EPM_RG_SETUP)
			rd_next = setup_mem[offset[2:0]];
		else if (region == `EPM_RG_CSR)
			rd_next = csr_rdata;
		else if (region == `EPM_RG_EP0 || region == `EPM_RG_EP1O ||
			region == `EPM_RG_EP1I)
			rd_next = small_mem[small_idx];
		else if (region == `EPM_RG_BIG && big_ok)
			rd_next = big_mem[offset[11:0]];
		else
			rd_next = 8'h00;
	end

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mem_rdata <= 8'h00;
			mem_ack   <= 1'b0;
			mem_hit   <= 1'b0;
		end else begin
			mem_ack   <= mem_req;
			mem_hit   <= mem_req && (region != `EPM_RG_NONE);
			mem_rdata <= (mem_req && !mem_we) ? rd_next : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Endpoint arrangement

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_reg <= 4'h0;
			alt_reg <= 2'h0;
			hs_reg  <= 1'b0;
			cfg_bad <= 1'b0;
		end else begin
			hs_reg  <= high_speed;
			alt_reg <= alt_sel;
			if (cfg_sel < `EPM_NUM_CFG) begin
				cfg_reg <= cfg_sel;
				cfg_bad <= 1'b0;
			end else begin
				cfg_bad <= 1'b1;
			end
		end
	end

	// Twelve arrangements: depth of ep2/ep6 and packet size of ep2/ep6
	always @* begin
		d2_next = 3'h2;
		d6_next = 3'h2;
		p2_next = `EPM_HS_PKT;
		p6_next = `EPM_HS_PKT;
		case (cfg_reg)
			4'h0: begin d2_next = 3'h2; d6_next = 3'h2; end
			4'h1: begin d2_next = 3'h2; d6_next = 3'h3; end
			4'h2: begin d2_next = 3'h2; d6_next = 3'h4; end
			4'h3: begin d2_next = 3'h3; d6_next = 3'h2; end
			4'h4: begin d2_next = 3'h3; d6_next = 3'h3; end
			4'h5: begin d2_next = 3'h4; d6_next = 3'h2; end
			4'h6: begin d2_next = 3'h4; d6_next = 3'h4; end
			4'h7: begin d2_next = 3'h2; d6_next = 3'h4; p2_next = 11'h400; end
			4'h8: begin d2_next = 3'h2; d6_next = 3'h2; p2_next = 11'h400; end
			4'h9: begin d2_next = 3'h3; d6_next = 3'h2; p2_next = 11'h400; end
			4'hA: begin d2_next = 3'h2; d6_next = 3'h2; p6_next = 11'h400; end
			4'hB: begin d2_next = 3'h4; d6_next = 3'h2; p2_next = 11'h400; end
			default: begin d2_next = 3'h2; d6_next = 3'h2; end
		endcase
	end

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_active     <= 4'h0;
			depth_ep2      <= 3'h2;
			depth_ep4      <= 3'h2;
			depth_ep6      <= 3'h2;
			depth_ep8      <= 3'h2;
			pkt_ep2        <= 11'h000;
			pkt_ep6        <= 11'h000;
			type_ep1       <= `EPM_TT_NONE;
			type_ep2       <= `EPM_TT_NONE;
			type_ep4       <= `EPM_TT_NONE;
			type_ep6       <= `EPM_TT_NONE;
			type_ep8       <= `EPM_TT_NONE;
			ep1_report_pkt <= 11'h000;
			ep1_hold_pkt   <= `EPM_SMALL_PKT;
			ep0_pkt        <= `EPM_SMALL_PKT;
		end else begin
			cfg_active   <= cfg_reg;
			ep0_pkt      <= `EPM_SMALL_PKT;
			ep1_hold_pkt <= `EPM_SMALL_PKT;
			depth_ep2    <= d2_next;
			depth_ep6    <= d6_next;
			depth_ep4    <= 3'h2;
			depth_ep8    <= 3'h2;
			pkt_ep2 <= hs_reg ? p2_next : `EPM_FS_PKT;
			pkt_ep6 <= hs_reg ? p6_next : `EPM_FS_PKT;
			case (alt_reg)
				2'h0: begin
					type_ep1       <= `EPM_TT_NONE;
					type_ep2       <= `EPM_TT_NONE;
					type_ep4       <= `EPM_TT_NONE;
					type_ep6       <= `EPM_TT_NONE;
					type_ep8       <= `EPM_TT_NONE;
					ep1_report_pkt <= 11'h000;
					pkt_ep2        <= 11'h000;
					pkt_ep6        <= 11'h000;
				end
				2'h1: begin
					type_ep1 <= `EPM_TT_BULK;
					type_ep2 <= `EPM_TT_BULK;
					type_ep4 <= `EPM_TT_BULK;
					type_ep6 <= `EPM_TT_BULK;
					type_ep8 <= `EPM_TT_BULK;
					ep1_report_pkt <= hs_reg ? `EPM_HS_PKT : `EPM_FS_PKT;
				end
				2'h2: begin
					type_ep1       <= `EPM_TT_INT;
					type_ep2       <= `EPM_TT_INT;
					type_ep4       <= `EPM_TT_BULK;
					type_ep6       <= `EPM_TT_INT;
					type_ep8       <= `EPM_TT_BULK;
					ep1_report_pkt <= `EPM_SMALL_PKT;
				end
				default: begin
					type_ep1       <= `EPM_TT_INT;
					type_ep2       <= `EPM_TT_ISO;
					type_ep4       <= `EPM_TT_BULK;
					type_ep6       <= `EPM_TT_ISO;
					type_ep8       <= `EPM_TT_BULK;
					ep1_report_pkt <= `EPM_SMALL_PKT;
				end
			endcase
		end
	end

endmodule

// ==== dv/epm_map_monitor.sv ====
// Concurrent checks on the memory map and layout ports
module epm_map_monitor (
	input logic        ref_clk,
	input logic        sys_rst,
	input logic        mem_req,
	input logic        mem_dl_path,
	input logic [15:0] mem_addr,
	input logic [7:0]  mem_rdata,
	input logic        mem_ack,
	input logic        mem_hit,
	input logic        csr_sel,
	input logic [3:0]  cfg_sel,
	input logic [3:0]  cfg_active,
	input logic [2:0]  depth_ep4,
	input logic [2:0]  depth_ep8,
	input logic [10:0] ep0_pkt,
	input logic [10:0] ep1_hold_pkt
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	wire [15:0] a = mem_addr;
	wire in_prg = a < 16'h4000;
	wire in_scr = a >= 16'hE000 && a <= 16'hE1FF;
	wire in_set = a >= 16'hE6B8 && a <= 16'hE6BF;
	wire in_csr = a >= 16'hE500 && a <= 16'hE6FF && !in_set;
	wire in_rsv = (a >= 16'hE200 && a <= 16'hE3FF) || (a >= 16'hE480 && a <= 16'hE4FF)
		|| (a >= 16'hE700 && a <= 16'hE73F) || (a >= 16'hE800 && a <= 16'hEFFF);
	////////////////////////////////////////////////////////////////////////////
	AST_ACK:
		assert property (mem_req ##1 !mem_req |-> mem_ack ##1 !mem_ack) else $error("ack");
	AST_PRG:
		assert property (mem_req && in_prg |=> mem_hit) else $error("prg miss");
	AST_DL:
		assert property (mem_req && mem_dl_path && !in_prg && !in_scr
			|=> !mem_hit && mem_rdata == 8'h00) else $error("dl leak");
	AST_CSR:
		assert property (mem_req && !mem_dl_path |-> csr_sel == in_csr) else $error("csr");
	AST_RSV:
		assert property (mem_req && in_rsv |=> !mem_hit && mem_rdata == 8'h00)
			else $error("rsv");
	AST_CFG:
		assert property ((cfg_sel < 4'hC && $stable(cfg_sel)) [*3] |-> cfg_active == cfg_sel)
			else $error("cfg");
	AST_DEPTH:
		assert property (depth_ep4 == 3'h2 && depth_ep8 == 3'h2) else $error("depth");
	AST_EP0:
		assert property (ep0_pkt == 11'h040 && ep1_hold_pkt == 11'h040) else $error("pkt");
endmodule

bind epm_endpoint_memory_map epm_map_monitor i_epm_map_monitor (.*);

// ==== dv/epm_csr_model.sv ====
// Behavioural register file behind the control register window
module epm_csr_model (
	input logic        ref_clk,
	input logic        csr_sel,
	input logic [15:0] mem_addr,
	output logic [7:0] csr_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] churn_reg = 8'h00;
	// Unselected, the bus shows a byte that moves every cycle
	always @(posedge ref_clk) churn_reg <= churn_reg + 8'h35;
	assign csr_rdata = csr_sel ? mem_addr[7:0] ^ 8'hA5 : churn_reg;
endmodule

// ==== dv/tb_epm_endpoint_memory_map.sv ====
// Self-checking bench for the endpoint memory map
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin errors++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module tb_epm_endpoint_memory_map;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk, sys_rst, mem_req, mem_we, mem_dl_path, high_speed;
	logic        mem_ack, mem_hit, csr_sel, cfg_bad;
	logic [15:0] mem_addr;
	logic [7:0]  mem_wdata, mem_rdata, csr_rdata;
	logic [3:0]  cfg_sel, cfg_active;
	logic [1:0]  alt_sel, type_ep1, type_ep2, type_ep4, type_ep6, type_ep8;
	logic [2:0]  depth_ep2, depth_ep4, depth_ep6, depth_ep8;
	logic [10:0] pkt_ep2, pkt_ep6, ep1_report_pkt, ep1_hold_pkt, ep0_pkt;
	int          errors, checked, cycles;
	epm_endpoint_memory_map i_epm_endpoint_memory_map (.*);
	epm_csr_model i_epm_csr_model (.*);
	////////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic idle(input int n);
		mem_req = 1'b0;
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic acc(input logic we, dl, input logic [15:0] a, input logic [7:0] d, er,
		input logic eh);
		mem_req = 1'b1;
		mem_we = we;
		mem_dl_path = dl;
		mem_addr = a;
		mem_wdata = d;
		@(posedge ref_clk);
		#1;
		`CHK("ack", 1'b1, mem_ack)
		`CHK("hit", eh, mem_hit)
		`CHK("rdata", er, mem_rdata)
	endtask
	// Write an address-derived byte, then read it back
	task automatic pair(input logic dl, input logic [15:0] a, input logic eh, kept);
		acc(1'b1, dl, a, a[7:0] ^ 8'h3C, 8'h00, eh);
		acc(1'b0, dl, a, 8'h00, kept ? a[7:0] ^ 8'h3C : 8'h00, eh);
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_mem();
		pair(1'b0, 16'h0000, 1'b1, 1'b1);
		pair(1'b0, 16'h3FFF, 1'b1, 1'b1);
		pair(1'b0, 16'hE000, 1'b1, 1'b1);
		pair(1'b1, 16'h2000, 1'b1, 1'b1);
		pair(1'b1, 16'hE1FF, 1'b1, 1'b1);
		pair(1'b1, 16'hE400, 1'b0, 1'b0);
		pair(1'b1, 16'hE780, 1'b0, 1'b0);
		pair(1'b1, 16'h4000, 1'b0, 1'b0);
		acc(1'b0, 1'b1, 16'hE500, 8'h00, 8'h00, 1'b0);
		idle(1);
	endtask
	task automatic t_win();
		pair(1'b0, 16'hE400, 1'b1, 1'b1);
		pair(1'b0, 16'hE47F, 1'b1, 1'b1);
		acc(1'b0, 1'b0, 16'hE500, 8'h00, 8'hA5, 1'b1);
		acc(1'b0, 1'b0, 16'hE6FF, 8'h00, 8'h5A, 1'b1);
		pair(1'b0, 16'hE6B8, 1'b1, 1'b1);
		pair(1'b0, 16'hE6BF, 1'b1, 1'b1);
		pair(1'b0, 16'hE740, 1'b1, 1'b1);
		pair(1'b0, 16'hE780, 1'b1, 1'b1);
		pair(1'b0, 16'hE7C0, 1'b1, 1'b1);
		pair(1'b0, 16'hE7FF, 1'b1, 1'b1);
		idle(1);
	endtask
	task automatic t_big();
		high_speed = 1'b1;
		idle(2);
		pair(1'b0, 16'hF000, 1'b1, 1'b1);
		pair(1'b0, 16'hF1C0, 1'b1, 1'b1);
		pair(1'b0, 16'hFFFF, 1'b1, 1'b1);
		high_speed = 1'b0;
		idle(2);
		pair(1'b0, 16'hF03F, 1'b1, 1'b1);
		pair(1'b0, 16'hF040, 1'b1, 1'b0);
		pair(1'b0, 16'hFFFF, 1'b1, 1'b0);
		idle(1);
	endtask
	task automatic t_rsv();
		logic [15:0] r[8] = '{16'hE200, 16'hE3FF, 16'hE480, 16'hE4FF,
			16'hE700, 16'hE73F, 16'hE800, 16'hEFFF};
		foreach (r[i]) pair(1'b0, r[i], 1'b0, 1'b0);
		idle(1);
	endtask
	task automatic t_cfg();
		high_speed = 1'b1;
		alt_sel = 2'h1;
		for (int c = 0; c < 16; c++) begin
			cfg_sel = c[3:0];
			idle(4);
			`CHK("cfg_active", c < 12 ? c[3:0] : 4'hB, cfg_active)
			`CHK("cfg_bad", c > 11, cfg_bad)
			`CHK("depth_ep4", 3'h2, depth_ep4)
			`CHK("depth_ep2", 1'b1, depth_ep2 >= 3'h2 && depth_ep2 <= 3'h4)
			`CHK("depth_ep6", 1'b1, depth_ep6 >= 3'h2 && depth_ep6 <= 3'h4)
			`CHK("depth_ep8", 3'h2, depth_ep8)
			`CHK("pkt_ep2", 1'b1, pkt_ep2 == 11'h200 || pkt_ep2 == 11'h400)
			`CHK("pkt_ep6", 1'b1, pkt_ep6 == 11'h200 || pkt_ep6 == 11'h400)
		end
		cfg_sel = 4'h0;
		idle(3);
	endtask
	task automatic t_alt();
		for (int s = 0; s < 2; s++) begin
			for (int k = 0; k < 4; k++) begin
				high_speed = s[0];
				alt_sel = k[1:0];
				idle(2);
				`CHK("type_ep1", k > 1 ? 2'h2 : k[1:0], type_ep1)
				`CHK("type_ep2", k[1:0], type_ep2)
				`CHK("type_ep4", {1'b0, k != 0}, type_ep4)
				`CHK("type_ep6", k[1:0], type_ep6)
				`CHK("type_ep8", {1'b0, k != 0}, type_ep8)
				`CHK("pkt_ep2", k == 0 ? 11'h0 : s ? 11'h200 : 11'h040, pkt_ep2)
				`CHK("pkt_ep6", k == 0 ? 11'h0 : s ? 11'h200 : 11'h040, pkt_ep6)
				`CHK("ep1_rep", k == 0 ? 11'h0 : s && k == 1 ? 11'h200 : 11'h040,
					ep1_report_pkt)
			end
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		errors = 0;
		checked = 0;
		cycles = 0;
		sys_rst = 1'b1;
		mem_req = 1'b0;
		mem_we = 1'b0;
		mem_dl_path = 1'b0;
		mem_addr = 16'h0000;
		mem_wdata = 8'h00;
		cfg_sel = 4'h0;
		alt_sel = 2'h0;
		high_speed = 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		sys_rst = 1'b0;
		t_mem();
		t_win();
		t_big();
		t_rsv();
		t_cfg();
		t_alt();
		print_verdict();
	end
endmodule
